// File: tb/frh_fault_response_tb.sv
`timescale 1ns/1ns
`include "frh_cfg.svh"
module frh_fault_response_tb;
	localparam int MS = 10;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic oc = 1'b0, ot = 1'b0, run = 1'b0, ramp = 1'b0, op = 1'b0;
	logic ton = 1'b0, clr = 1'b0, fp = 1'b1;
	logic [7:0] die = 8'h19;
	logic [4:0] mask = 5'h00;
	logic cv, cw, rv, re, an, aoe, en;
	logic [7:0] cc;
	logic [15:0] cd, rd, got;
	int n_errors = 0, check_count = 0, cyc = 0, seed = 59, n;
	logic [7:0] mreg [logic [7:0]]; // Model of response bytes.
	wire alert_w = aoe ? 1'b1 : an; // Pulled up when released.
	frh_fault_response #(.MS_CYCLES(MS)) uut (.clk_in(clk_in),
		.srst_in(srst_in), .oc_detect_in(oc), .ext_ot_in(ot),
		.run_in(run), .fault_pin_n_in(fp), .ramp_in(ramp),
		.operation_on_in(op), .ton_max_in(ton), .die_temp_in(die),
		.clear_faults_in(clr), .restore_user_all_in(1'b0),
		.soft_reset_in(1'b0), .alert_mask_in(mask), .cmd_valid_in(cv),
		.cmd_write_in(cw), .cmd_code_in(cc), .cmd_data_in(cd),
		.alert_n_in(alert_w), .rsp_valid_out(rv), .rsp_data_out(rd),
		.rsp_err_out(re), .alert_n_out(an), .alert_oe_n_out(aoe),
		.output_enable_out(en));
	frh_host_model host (.clk_in(clk_in), .rsp_data_in(rd),
		.cmd_valid_out(cv), .cmd_write_out(cw), .cmd_code_out(cc),
		.cmd_data_out(cd));
	always #5 clk_in = ~clk_in;
	// Cuts a hang short.
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Reads a code and compares the bits under m with e.
	task automatic rd_chk(input logic [7:0] c, input logic [15:0] m,
		input logic [15:0] e);
		host.read(c, got);
		check(got & m, e);
		// The answer strobe stands now; only the unknown code 01 is refused.
		check({rv, re}, {1'b1, c == 8'h01});
	endtask
	// Writes a byte and keeps the model in step if it is accepted.
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		host.send(1'b1, c, {8'h00, d});
		if (c == 8'h46 && d[7:6] != 2'h1) begin
			mreg[c] = d;
		end else if ((c == 8'h50 || c == 8'h63) && !d[6]) begin
			mreg[c] = d;
		end
	endtask
	task automatic wait_en(input logic e, input int lim);
		n = 0;
		while (en !== e && n < lim) begin
			@(negedge clk_in);
			n++;
		end
		check(en, e);
	endtask
	task automatic clear();
		@(negedge clk_in);
		clr = 1'b1;
		@(negedge clk_in);
		clr = 1'b0;
	endtask
	initial begin
		mreg[8'h46] = `FRH_OC_RESP_RST;
		mreg[8'h50] = `FRH_OT_RESP_RST;
		mreg[8'h63] = `FRH_TON_RESP_RST;
		mreg[8'hd6] = `FRH_DIE_RESP;
		repeat (6) @(negedge clk_in);
		srst_in = 1'b0;
		run = 1'b1;
		op = 1'b1;
		foreach (mreg[c]) rd_chk(c, 16'h00ff, mreg[c]);
		rd_chk(8'hdb, 16'hffff, `FRH_RETRY_RST);
		wait_en(1'b1, 20);
		// Refused writes keep the register and raise a data fault.
		wr(8'hd6, 8'h00);
		wr(8'h46, 8'h40);
		wr(8'h50, 8'hc0);
		wr(8'h63, 8'h40);
		foreach (mreg[c]) rd_chk(c, 16'h00ff, mreg[c]);
		rd_chk(8'h01, 16'h0000, 16'h0000);
		rd_chk(8'h7e, 16'h0040, 16'h0040);
		check(alert_w, 1'b0);
		clear();
		repeat (2) @(negedge clk_in);
		check(alert_w, 1'b1);
		// Immediate shutdown without restart.
		wr(8'h46, 8'hc0 | ($random(seed) & 7));
		oc = 1'b1;
		wait_en(1'b0, 8);
		rd_chk(8'h78, 16'h0010, 16'h0010);
		rd_chk(8'h79, 16'h4000, 16'h4000);
		rd_chk(8'h7b, 16'h0080, 16'h0080);
		check(alert_w, 1'b0);
		oc = 1'b0;
		repeat (50) @(negedge clk_in);
		check(en, 1'b0);
		wr(8'h7b, 8'h80);
		wait_en(1'b1, 8);
		// Ramp hides overcurrent.
		ramp = 1'b1;
		oc = 1'b1;
		repeat (20) @(negedge clk_in);
		rd_chk(8'h7b, 16'h0080, 16'h0000);
		oc = 1'b0;
		repeat (6) @(negedge clk_in);
		ramp = 1'b0;
		// Response 00 keeps running; a mask keeps alert released.
		wr(8'h46, 8'h00);
		mask = 5'h01;
		oc = 1'b1;
		repeat (40) @(negedge clk_in);
		check(en, 1'b1);
		check(alert_w, 1'b1);
		oc = 1'b0;
		mask = 5'h00;
		clear();
		// One delay step, interrupted once, then held.
		wr(8'h46, 8'h81);
		oc = 1'b1;
		repeat (100) @(negedge clk_in);
		oc = 1'b0;
		repeat (10) @(negedge clk_in);
		oc = 1'b1;
		wait_en(1'b0, 400);
		check(n >= 16 * MS + 8 && n <= 17 * MS + 8, 1'b1);
		oc = 1'b0;
		clear();
		wait_en(1'b1, 8);
		// External overtemperature, off at once, endless retry.
		host.send(1'b1, 8'hdb, `FRH_RETRY_MIN_MS);
		wr(8'h50, 8'hb8 | ($random(seed) & 7));
		ot = 1'b1;
		wait_en(1'b0, 8);
		rd_chk(8'h78, 16'h0004, 16'h0004);
		rd_chk(8'h7d, 16'h0080, 16'h0080);
		// Pin release starts the interval although the fault stays.
		fp = 1'b0;
		repeat (6) @(negedge clk_in);
		fp = 1'b1;
		wait_en(1'b1, 1300);
		check(n >= 120 * MS + 8 && n <= 121 * MS + 8, 1'b1);
		ot = 1'b0;
		repeat (2) @(negedge clk_in);
		check(en, 1'b0);
		wait_en(1'b1, 1300);
		clear();
		// Turn-on timeout without restart.
		wr(8'h63, 8'h80);
		ton = 1'b1;
		wait_en(1'b0, 8);
		ton = 1'b0;
		rd_chk(8'h79, 16'h8000, 16'h8000);
		rd_chk(8'h7a, 16'h0004, 16'h0004);
		clear();
		wait_en(1'b1, 8);
		// Die temperature hysteresis.
		die = 8'ha1;
		wait_en(1'b0, 6);
		rd_chk(8'h79, 16'h1000, 16'h1000);
		rd_chk(8'h80, 16'h0040, 16'h0040);
		die = 8'h96;
		repeat (10) @(negedge clk_in);
		check(en, 1'b0);
		die = 8'h95;
		wait_en(1'b1, 6);
		finish_test();
	end
endmodule

// File: tb/frh_host_model.sv
`timescale 1ns/1ns
// Host on the command port; strobes change only at the falling edge.
module frh_host_model (
	input wire logic clk_in,
	input wire logic [15:0] rsp_data_in,
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output logic [7:0] cmd_code_out,
	output logic [15:0] cmd_data_out
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_data_out = 16'h0000;
	end
	// One strobe cycle; data is inverted after so stale data is not reused.
	task automatic send(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = w;
		cmd_code_out = c;
		cmd_data_out = d;
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		cmd_data_out = ~d;
	endtask
	// The answer stands from the taking edge and is read half a cycle after it.
	task automatic read(input logic [7:0] c, output logic [15:0] d);
		send(1'b0, c, 16'h0000);
		d = rsp_data_in;
	endtask
endmodule

// File: verilog/frh_cfg.svh
`ifndef FRH_CFG_SVH
`define FRH_CFG_SVH
// Clock period and the millisecond from which all fault timing is built.
`define FRH_CLK_NS 10
`define FRH_MS_NS 1000000
`define FRH_MS_CNT_W 17
// Persistence delay step and the shortest legal restart interval.
`define FRH_STEP_MS 16
`define FRH_RETRY_MIN_MS 16'h0078
// Die temperature thresholds in degrees Celsius.
`define FRH_DIE_HOT_C 8'ha0
`define FRH_DIE_COOL_C 8'h96
// Response byte values after reset.
`define FRH_DIE_RESP 8'hc0
`define FRH_OT_RESP_RST 8'hb8
`define FRH_TON_RESP_RST 8'hb8
`define FRH_OC_RESP_RST 8'h00
`define FRH_RETRY_RST 16'h015e
// Response byte fields.
`define FRH_ACT_IGNORE 2'h0
`define FRH_ACT_BAD 2'h1
`define FRH_ACT_MID 2'h2
`define FRH_ACT_TOP 2'h3
`define FRH_RETRY_ALWAYS 3'h7
// Command codes on the command port.
`define FRH_CMD_OC_RESP 8'h46
`define FRH_CMD_OT_RESP 8'h50
`define FRH_CMD_TON_RESP 8'h63
`define FRH_CMD_DIE_RESP 8'hd6
`define FRH_CMD_RETRY 8'hdb
`define FRH_CMD_SBYTE 8'h78
`define FRH_CMD_SWORD 8'h79
`define FRH_CMD_SVOUT 8'h7a
`define FRH_CMD_SIOUT 8'h7b
`define FRH_CMD_STEMP 8'h7d
`define FRH_CMD_SCML 8'h7e
`define FRH_CMD_SMFR 8'h80
// Sticky flag indices and channel indices.
`define FRH_FL_OC 0
`define FRH_FL_OT 1
`define FRH_FL_TON 2
`define FRH_FL_DIE 3
`define FRH_FL_CML 4
`define FRH_FL_N 5
`define FRH_CH_OC 0
`define FRH_CH_OT 1
`define FRH_CH_TON 2
`define FRH_CH_N 3
// Status bit positions.
`define FRH_SB_IOUT_OC 4
`define FRH_SB_TEMP 2
`define FRH_SB_CML 1
`define FRH_SW_VOUT 15
`define FRH_SW_IOUT 14
`define FRH_SW_MFR 12
`define FRH_S_IOUT_OC 7
`define FRH_S_TEMP_OT 7
`define FRH_S_VOUT_TON 2
`define FRH_S_MFR_OT 6
`define FRH_S_CML_DATA 6
`endif

// File: verilog/frh_chan_if.sv
`timescale 1ns/1ns
// Signals between the top and one fault response channel.
interface frh_chan_if;
	logic [7:0] resp; // Programmed response byte.
	logic fault; // Qualified fault level.
	logic clear; // Fault clearing event.
	logic ms_tick; // One pulse per millisecond.
	logic run_on; // Output is commanded on.
	logic pin_rel; // Shared fault pin was released.
	logic [15:0] interval; // Restart interval in ms.
	logic off; // Channel holds the output off.
	modport ctl(output resp, fault, clear, ms_tick, run_on, pin_rel,
		interval, input off);
	modport chan(input resp, fault, clear, ms_tick, run_on, pin_rel,
		interval, output off);
endinterface

// File: verilog/frh_fault_response.sv
`timescale 1ns/1ns
`include "frh_cfg.svh"
// Behaviour
// RULE1 - overcurrent sets byte, word and current status
// RULE2 - recorded faults drive alert unless masked
// RULE3 - overcurrent ignored during output ramps
// RULE4 - response 00 never disables output
// RULE5 - writing 01 raises communication fault
// RULE6 - response 10 disables after persistent delay
// RULE7 - response 11 disables at once
// RULE8 - retry 000-110 stays off until cleared
// RULE9 - retry 111 restarts endlessly after interval
// RULE10 - delay field counts 16 ms steps
// RULE11 - overcurrent flag clears only on listed events
// RULE12 - external overtemperature sets byte and temperature status
// RULE13 - die overtemperature sets word and vendor status
// RULE14 - die response fixed, 160 off, 150 on
// RULE15 - die response byte is read only
// RULE16 - turn-on timeout sets word and vout status
// RULE17 - temperature and timeout 10 shut down
// RULE18 - 00 runs on, 01 and 11 unsupported
// RULE19 - temperature and timeout delay bits ignored
// RULE20 - retry interval starts after fault or pin release
// RULE21 - vanishing fault restarts the persistence delay
module frh_fault_response import frh_pkg::*; #(
	parameter int MS_CYCLES = `FRH_MS_NS / `FRH_CLK_NS
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic oc_detect_in,
	input wire logic ext_ot_in,
	input wire logic run_in,
	input wire logic fault_pin_n_in,
	input wire logic ramp_in,
	input wire logic operation_on_in,
	input wire logic ton_max_in,
	input wire logic [7:0] die_temp_in,
	input wire logic clear_faults_in,
	input wire logic restore_user_all_in,
	input wire logic soft_reset_in,
	input wire logic [4:0] alert_mask_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_data_in,
	input wire logic alert_n_in,
	output logic rsp_valid_out,
	output logic [15:0] rsp_data_out,
	output logic rsp_err_out,
	output logic alert_n_out,
	output logic alert_oe_n_out,
	output logic output_enable_out
);
	logic [3:0] pins_s; // Synchronised pin levels.
	logic oc_s, ot_s, run_s, pin_s; // Named pin levels.
	logic pin_q; // Previous fault pin level.
	logic run_on, run_on_q; // Output commanded on, and its last value.
	logic off_on; // Output just commanded on again.
	logic pin_rel; // Fault pin just released.
	logic clear_all; // Any event that clears every flag.
	logic oc_qual; // Overcurrent outside of ramps.
	logic [`FRH_MS_CNT_W-1:0] ms_cnt_q; // Millisecond prescaler.
	logic ms_tick; // One pulse per millisecond.
	logic [7:0] oc_resp_q, ot_resp_q, ton_resp_q; // Response bytes.
	logic [15:0] retry_q; // Restart interval in ms.
	logic [15:0] interval; // Interval held to its legal floor.
	logic die_hot_q; // Die hot: set above its shutdown threshold, held until it falls below the cool one.
	logic [`FRH_FL_N-1:0] flag_q, flag_set, flag_clr; // Sticky flags.
	logic cml_evt; // Bad write or unknown command.
	logic wr, rd; // Command port write and read.
	logic [7:0] wbyte; // Low data byte of a write.
	logic [7:0] sbyte; // Summary status byte.
	logic [15:0] sword; // Summary status word.
	logic [15:0] rdata; // Read data before the register.
	logic rerr; // Read of an unknown code.
	logic alert_q; // Alert pulled low.
	logic en_q; // Output enable register.
	logic [7:0] resp_v [`FRH_CH_N]; // Response per channel.
	logic fault_v [`FRH_CH_N]; // Fault per channel.
	logic off_v [`FRH_CH_N]; // Shutdown per channel.
	logic clr_v [`FRH_CH_N]; // Clearing event per channel.
	frh_chan_if ch_if [`FRH_CH_N] ();

	// The alert line is only ever pulled low; the board pulls it up.
	assign alert_n_out = 1'b0;
	assign alert_oe_n_out = ~alert_q;

	// Pins from outside pass three stages before use.
	frh_sync3 #(.W(4), .RST(4'h8)) u_sync (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.pin_in({fault_pin_n_in, run_in, ext_ot_in, oc_detect_in}),
		.level_out(pins_s)
	);
	assign oc_s = pins_s[0];
	assign ot_s = pins_s[1];
	assign run_s = pins_s[2];
	assign pin_s = pins_s[3];

	// Overcurrent detections during turn-on and turn-off are dropped.
	assign oc_qual = oc_s && !ramp_in; // RULE3
	assign run_on = run_s && operation_on_in;
	assign off_on = run_on && !run_on_q;
	assign pin_rel = pin_s && !pin_q;
	assign clear_all = clear_faults_in || restore_user_all_in ||
		soft_reset_in || off_on; // RULE11
	assign wr = cmd_valid_in && cmd_write_in;
	assign rd = cmd_valid_in && !cmd_write_in;
	assign wbyte = cmd_data_in[7:0];
	assign interval = (retry_q < `FRH_RETRY_MIN_MS) ? `FRH_RETRY_MIN_MS :
		retry_q; // RULE20

	// Edge memories for the run command and the fault pin.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			run_on_q <= 1'b0;
			pin_q <= 1'b1;
		end else begin
			run_on_q <= run_on;
			pin_q <= pin_s;
		end
	end

	// Millisecond prescaler shared by every channel.
	always_ff @(posedge clk_in) begin
		if (srst_in || ms_tick) begin
			ms_cnt_q <= '0;
		end else begin
			ms_cnt_q <= ms_cnt_q + `FRH_MS_CNT_W'(1);
		end
	end
	assign ms_tick = ms_cnt_q == `FRH_MS_CNT_W'(MS_CYCLES - 1);

	// Response registers; unsupported values are refused and kept out.
	always_ff @(posedge clk_in) begin
		if (srst_in || soft_reset_in) begin
			oc_resp_q <= `FRH_OC_RESP_RST;
			ot_resp_q <= `FRH_OT_RESP_RST;
			ton_resp_q <= `FRH_TON_RESP_RST;
			retry_q <= `FRH_RETRY_RST;
		end else if (wr && cmd_code_in == `FRH_CMD_OC_RESP) begin
			if (wbyte[7:6] != `FRH_ACT_BAD) begin
				oc_resp_q <= wbyte; // RULE5
			end
		end else if (wr && cmd_code_in == `FRH_CMD_OT_RESP) begin
			if (wbyte[7:6] == `FRH_ACT_IGNORE || wbyte[7:6] == `FRH_ACT_MID) begin
				ot_resp_q <= wbyte; // RULE18
			end
		end else if (wr && cmd_code_in == `FRH_CMD_TON_RESP) begin
			if (wbyte[7:6] == `FRH_ACT_IGNORE || wbyte[7:6] == `FRH_ACT_MID) begin
				ton_resp_q <= wbyte; // RULE18
			end
		end else if (wr && cmd_code_in == `FRH_CMD_RETRY) begin
			retry_q <= cmd_data_in;
		end
	end

	// Classify every command for the communication fault.
	always_comb begin
		cml_evt = 1'b0;
		if (wr && cmd_code_in == `FRH_CMD_OC_RESP) begin
			cml_evt = wbyte[7:6] == `FRH_ACT_BAD; // RULE5
		end else if (wr && (cmd_code_in == `FRH_CMD_OT_RESP ||
			cmd_code_in == `FRH_CMD_TON_RESP)) begin
			cml_evt = wbyte[7:6] == `FRH_ACT_BAD ||
				wbyte[7:6] == `FRH_ACT_TOP; // RULE18
		end else if (wr && cmd_code_in == `FRH_CMD_DIE_RESP) begin
			cml_evt = 1'b1; // RULE15
		end else if (cmd_valid_in && rerr) begin
			cml_evt = 1'b1;
		end
	end

	// Die temperature with hysteresis; it needs no response byte.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			die_hot_q <= 1'b0;
		end else if (die_temp_in > `FRH_DIE_HOT_C) begin
			die_hot_q <= 1'b1; // RULE14
		end else if (die_temp_in < `FRH_DIE_COOL_C) begin
			die_hot_q <= 1'b0; // RULE14
		end
	end

	// Events that set sticky flags.
	always_comb begin
		flag_set = '0;
		flag_set[`FRH_FL_OC] = oc_qual; // RULE1
		flag_set[`FRH_FL_OT] = ot_s; // RULE12
		flag_set[`FRH_FL_TON] = ton_max_in; // RULE16
		flag_set[`FRH_FL_DIE] = die_hot_q; // RULE13
		flag_set[`FRH_FL_CML] = cml_evt;
	end

	// Clearing events: global ones, or a one written to the flag's bit.
	always_comb begin
		flag_clr = {`FRH_FL_N{clear_all}};
		if (wr && cmd_code_in == `FRH_CMD_SIOUT) begin
			flag_clr[`FRH_FL_OC] = clear_all || wbyte[`FRH_S_IOUT_OC]; // RULE11
		end else if (wr && cmd_code_in == `FRH_CMD_STEMP) begin
			flag_clr[`FRH_FL_OT] = clear_all || wbyte[`FRH_S_TEMP_OT];
		end else if (wr && cmd_code_in == `FRH_CMD_SVOUT) begin
			flag_clr[`FRH_FL_TON] = clear_all || wbyte[`FRH_S_VOUT_TON];
		end else if (wr && cmd_code_in == `FRH_CMD_SMFR) begin
			flag_clr[`FRH_FL_DIE] = clear_all || wbyte[`FRH_S_MFR_OT];
		end else if (wr && cmd_code_in == `FRH_CMD_SCML) begin
			flag_clr[`FRH_FL_CML] = clear_all || wbyte[`FRH_S_CML_DATA];
		end
	end

	// Sticky flags; a set in the same cycle as a clear wins.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_set | (flag_q & ~flag_clr); // RULE11
		end
	end

	// Alert follows any unmasked flag, whatever the response.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= |(flag_q & ~alert_mask_in); // RULE2
		end
	end

	// Summary status byte and word.
	always_comb begin
		sbyte = 8'h00;
		sbyte[`FRH_SB_IOUT_OC] = flag_q[`FRH_FL_OC]; // RULE1
		sbyte[`FRH_SB_TEMP] = flag_q[`FRH_FL_OT]; // RULE12
		sbyte[`FRH_SB_CML] = flag_q[`FRH_FL_CML];
		sword = {8'h00, sbyte};
		sword[`FRH_SW_IOUT] = flag_q[`FRH_FL_OC]; // RULE1
		sword[`FRH_SW_VOUT] = flag_q[`FRH_FL_TON]; // RULE16
		sword[`FRH_SW_MFR] = flag_q[`FRH_FL_DIE]; // RULE13
	end

	// Read decode; unknown codes answer zero with an error.
	always_comb begin
		rdata = 16'h0000;
		rerr = 1'b0;
		if (cmd_code_in == `FRH_CMD_OC_RESP) begin
			rdata = {8'h00, oc_resp_q};
		end else if (cmd_code_in == `FRH_CMD_OT_RESP) begin
			rdata = {8'h00, ot_resp_q};
		end else if (cmd_code_in == `FRH_CMD_TON_RESP) begin
			rdata = {8'h00, ton_resp_q};
		end else if (cmd_code_in == `FRH_CMD_DIE_RESP) begin
			rdata = {8'h00, `FRH_DIE_RESP}; // RULE15
		end else if (cmd_code_in == `FRH_CMD_RETRY) begin
			rdata = retry_q;
		end else if (cmd_code_in == `FRH_CMD_SBYTE) begin
			rdata = {8'h00, sbyte};
		end else if (cmd_code_in == `FRH_CMD_SWORD) begin
			rdata = sword;
		end else if (cmd_code_in == `FRH_CMD_SIOUT) begin
			rdata = 16'(flag_q[`FRH_FL_OC]) << `FRH_S_IOUT_OC; // RULE1
		end else if (cmd_code_in == `FRH_CMD_STEMP) begin
			rdata = 16'(flag_q[`FRH_FL_OT]) << `FRH_S_TEMP_OT; // RULE12
		end else if (cmd_code_in == `FRH_CMD_SVOUT) begin
			rdata = 16'(flag_q[`FRH_FL_TON]) << `FRH_S_VOUT_TON; // RULE16
		end else if (cmd_code_in == `FRH_CMD_SMFR) begin
			rdata = 16'(flag_q[`FRH_FL_DIE]) << `FRH_S_MFR_OT; // RULE13
		end else if (cmd_code_in == `FRH_CMD_SCML) begin
			rdata = 16'(flag_q[`FRH_FL_CML]) << `FRH_S_CML_DATA;
		end else begin
			rerr = 1'b1;
		end
	end

	// Read answer, one cycle after the request.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_data_out <= 16'h0000;
			rsp_err_out <= 1'b0;
		end else begin
			rsp_valid_out <= rd;
			rsp_err_out <= rd && rerr;
			if (rd) begin
				rsp_data_out <= rdata;
			end
		end
	end

	// Channel inputs: overcurrent, external temperature, turn-on time.
	assign resp_v[`FRH_CH_OC] = oc_resp_q;
	assign resp_v[`FRH_CH_OT] = ot_resp_q;
	assign resp_v[`FRH_CH_TON] = ton_resp_q;
	assign fault_v[`FRH_CH_OC] = oc_qual;
	assign fault_v[`FRH_CH_OT] = ot_s;
	assign fault_v[`FRH_CH_TON] = ton_max_in;
	// A one written to a channel's status bit also ends its latched shutdown.
	assign clr_v[`FRH_CH_OC] = flag_clr[`FRH_FL_OC]; // RULE8
	assign clr_v[`FRH_CH_OT] = flag_clr[`FRH_FL_OT]; // RULE8
	assign clr_v[`FRH_CH_TON] = flag_clr[`FRH_FL_TON]; // RULE8

	// One response channel each for overcurrent, external temperature and turn-on time.
	for (genvar i = 0; i < `FRH_CH_N; i++) begin : g_ch
		assign ch_if[i].resp = resp_v[i];
		assign ch_if[i].fault = fault_v[i];
		assign ch_if[i].clear = clr_v[i];
		assign ch_if[i].ms_tick = ms_tick;
		assign ch_if[i].run_on = run_on;
		assign ch_if[i].pin_rel = pin_rel;
		assign ch_if[i].interval = interval;
		assign off_v[i] = ch_if[i].off;
		frh_resp_chan #(.IS_OC(i == `FRH_CH_OC)) u_ch (
			.clk_in(clk_in),
			.srst_in(srst_in),
			.ch(ch_if[i])
		);
	end

	// Output runs when commanded on and no channel or die holds it off.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			en_q <= 1'b0;
		end else begin
			en_q <= run_on && !off_v[`FRH_CH_OC] && !off_v[`FRH_CH_OT] &&
				!off_v[`FRH_CH_TON] && !die_hot_q; // RULE14
		end
	end
	assign output_enable_out = en_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	a_oc_status: assert property (oc_qual |=> flag_q[`FRH_FL_OC]) // RULE1
		else $error("overcurrent did not set its flag");
	a_alert_drive: assert property ( // RULE2
		flag_q[`FRH_FL_OT] && !alert_mask_in[`FRH_FL_OT] |=> !alert_oe_n_out)
		else $error("unmasked flag did not pull alert");
	a_ramp_ignore: assert property ( // RULE3
		$rose(flag_q[`FRH_FL_OC]) |-> $past(oc_s && !ramp_in))
		else $error("overcurrent recorded during ramp");
	a_oc_runs_on: assert property ( // RULE4
		!off_v[`FRH_CH_OC] && oc_resp_q[7:6] == `FRH_ACT_IGNORE
		|=> !off_v[`FRH_CH_OC])
		else $error("ignore response disabled output");
	a_bad_write: assert property ( // RULE5
		wr && cmd_code_in == `FRH_CMD_OC_RESP && wbyte[7:6] == `FRH_ACT_BAD
		|=> flag_q[`FRH_FL_CML] && $stable(oc_resp_q))
		else $error("unsupported response value accepted");
	a_oc_at_once: assert property ( // RULE7
		run_on && oc_qual && !off_v[`FRH_CH_OC] &&
		oc_resp_q[7:6] == `FRH_ACT_TOP && !ms_tick ##1 run_on
		|=> off_v[`FRH_CH_OC])
		else $error("immediate response did not disable");
	a_die_hyst: assert property ( // RULE14
		die_temp_in > `FRH_DIE_HOT_C |=> die_hot_q ##1 !output_enable_out)
		else $error("hot die did not disable output");
	a_die_fixed: assert property ( // RULE15
		rd && cmd_code_in == `FRH_CMD_DIE_RESP
		|=> rsp_data_out == {8'h00, `FRH_DIE_RESP})
		else $error("die response not fixed");
	a_set_wins: assert property ( // RULE11
		oc_qual && clear_all |=> flag_q[`FRH_FL_OC])
		else $error("clear beat a new overcurrent");
	a_ton_status: assert property ( // RULE16
		ton_max_in |=> sword[`FRH_SW_VOUT] && flag_q[`FRH_FL_TON])
		else $error("timeout did not set status");
endmodule

// File: verilog/frh_pkg.sv
package frh_pkg;
	// States of one fault response channel, Gray coded along the path.
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_delay = 3'h1,
		st_wait = 3'h3,
		st_count = 3'h2,
		st_hold = 3'h6
	} frh_state_t;
endpackage

// File: verilog/frh_resp_chan.sv
`timescale 1ns/1ns
`include "frh_cfg.svh"
// One fault response channel: decides shutdown, delay and restart.
module frh_resp_chan import frh_pkg::*; #(
	parameter bit IS_OC = 1'b0
) (
	input wire logic clk_in,
	input wire logic srst_in,
	frh_chan_if.chan ch
);
	frh_state_t state_q, state_d; // Channel state.
	frh_state_t off_st; // State entered on shutdown.
	logic [15:0] cnt_q; // Millisecond counter.
	logic [15:0] dly_ms; // Persistence delay in ms.
	logic now_off; // Response shuts down at once.
	logic delayed; // Response shuts down after the delay.

	// Decode the response byte for this channel's kind.
	always_comb begin
		dly_ms = 16'(ch.resp[2:0]) * 16'(`FRH_STEP_MS); // RULE10
		if (IS_OC) begin
			now_off = ch.resp[7:6] == `FRH_ACT_TOP; // RULE7
			delayed = ch.resp[7:6] == `FRH_ACT_MID; // RULE6
		end else begin
			now_off = ch.resp[7:6] == `FRH_ACT_MID; // RULE17
			delayed = 1'b0; // RULE19
		end
		if (ch.resp[5:3] == `FRH_RETRY_ALWAYS) begin
			off_st = st_wait; // RULE9
		end else begin
			off_st = st_hold; // RULE8
		end
	end

	// Next state; an ignore response never leaves idle.
	always_comb begin
		state_d = state_q;
		case (state_q)
			st_idle: begin // RULE4
				if (ch.fault && ch.run_on && now_off) begin
					state_d = off_st;
				end else if (ch.fault && ch.run_on && delayed) begin
					state_d = st_delay;
				end
			end
			st_delay: begin
				if (!ch.fault) begin
					state_d = st_idle; // RULE21
				// The shared tick has an unknown phase, so one tick more
				// than the delay makes sure the whole delay has passed.
				end else if (dly_ms == 16'h0000 || cnt_q > dly_ms) begin
					state_d = off_st; // RULE6
				end
			end
			st_hold: begin
				if (ch.clear) begin
					state_d = st_idle; // RULE8
				end
			end
			st_wait: begin
				if (!ch.run_on) begin
					state_d = st_idle;
				end else if (!ch.fault || ch.pin_rel) begin
					state_d = st_count; // RULE20
				end
			end
			st_count: begin
				if (!ch.run_on || cnt_q > ch.interval) begin
					state_d = st_idle; // RULE9
				end
			end
			default: begin
				state_d = st_idle;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= st_idle;
		end else begin
			state_q <= state_d;
		end
	end

	// Millisecond counter, restarted on every change of state.
	always_ff @(posedge clk_in) begin
		if (srst_in || state_d != state_q) begin
			cnt_q <= 16'h0000;
		end else if (ch.ms_tick) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	assign ch.off = state_q == st_hold || state_q == st_wait ||
		state_q == st_count;

	a_delay_drop: assert property (@(posedge clk_in) disable iff (srst_in) // RULE21
		state_q == st_delay && !ch.fault |=> state_q == st_idle)
		else $error("delay did not restart when fault left");
	a_hold_stays: assert property (@(posedge clk_in) disable iff (srst_in) // RULE8
		state_q == st_hold && !ch.clear |=> ch.off)
		else $error("latched off released without clearing");
	a_retry_gap: assert property (@(posedge clk_in) disable iff (srst_in) // RULE20
		state_q == st_wait && ch.fault && !ch.pin_rel && ch.run_on
		|=> state_q == st_wait)
		else $error("retry interval began while fault present");
endmodule

// File: verilog/frh_sync3.sv
`timescale 1ns/1ns
// Three-stage pin synchroniser; a change counts once stages two and three
// agree, which filters a single-cycle glitch past the first stage.
module frh_sync3 #(
	parameter int W = 4,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);
	logic [W-1:0] s1_q; // First stage, read only by the second.
	logic [W-1:0] s2_q; // Second stage.
	logic [W-1:0] s3_q; // Third stage.

	// Shift the pins through the stages and accept agreeing bits.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			level_out <= RST;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_out <= (s2_q & ~(s2_q ^ s3_q)) | (level_out & (s2_q ^ s3_q));
		end
	end
endmodule
